// ==== logic/slct_pkg.sv ====
// Constants, field layouts and types for the capability exchange and training block.
package slct_pkg;

	// Clock period and the out-of-band interval, which is two thirds of a nanosecond.
	localparam longint CLK_NS   = 25;
	localparam longint OOBI_NUM = 2;
	localparam longint OOBI_DEN = 3;
	localparam longint CYC_DEN  = OOBI_DEN * CLK_NS;

	// Window times in out-of-band intervals.
	localparam longint RCD_OOBI = 750000;
	localparam longint TLT_OOBI = 28497920;
	localparam longint MTT_OOBI = 29998080;

	// Cycle counts: the delay is a least time, the two limits are longest times.
	localparam int unsigned RCD_CYC = int'((RCD_OOBI * OOBI_NUM + CYC_DEN - 1) / CYC_DEN);
	localparam int unsigned TLT_CYC = int'((TLT_OOBI * OOBI_NUM) / CYC_DEN);
	localparam int unsigned MTT_CYC = int'((MTT_OOBI * OOBI_NUM) / CYC_DEN);

	// Training pattern shape in dwords.
	localparam int unsigned PATTERN_DW = 64;
	localparam int unsigned DATA_DW    = 58;
	localparam int unsigned PSEQ_DW    = PATTERN_DW - DATA_DW;
	localparam logic [2:0]  MIN_DONE   = 3'h4;

	// Requested rate codes.
	localparam logic [3:0] RC_NONE = 4'h0;
	localparam logic [3:0] RC_G1   = 4'h8;
	localparam logic [3:0] RC_G2   = 4'h9;

	// Capability word layout, byte 0 in the top bits.
	localparam int         CAP_START_BIT = 31;
	localparam int         CAP_SHAPE_BIT = 30;
	localparam int         CAP_RATE_LSB  = 24;
	localparam int         CAP_SET_LSB   = 18;
	localparam int         CAP_PAR_BIT   = 0;
	localparam logic [31:0] CAP_USED_MASK = 32'hcffc_0001;

	// Scrambler seed.
	localparam logic [15:0] SCR_SEED = 16'hffff;

	// Register map and fields.
	localparam logic [7:0]  REG_CFG    = 8'h00;
	localparam logic [7:0]  REG_CMD    = 8'h04;
	localparam logic [7:0]  REG_TXCAP  = 8'h08;
	localparam logic [7:0]  REG_RXCAP  = 8'h0c;
	localparam logic [7:0]  REG_STAT   = 8'h10;
	localparam int          CFG_SET_LSB   = 0;
	localparam int          CFG_SHAPE_BIT = 8;
	localparam int          CFG_RATE_LSB  = 12;
	localparam int          CFG_MGMT_BIT  = 16;
	localparam int          CFG_SLOW_BIT  = 17;
	localparam int          CFG_MID_BIT   = 18;
	localparam int          CFG_PCTL_LSB  = 20;
	localparam logic [31:0] CFG_RST       = 32'h0006_0000;
	localparam int          CMD_START_BIT = 0;
	localparam int          CMD_ABORT_BIT = 1;

	// Line rates.
	typedef enum logic [1:0] {RATE_G1, RATE_G2, RATE_G3} slct_rate_t;

	// Kind of dword being transmitted.
	typedef enum logic [2:0] {TXK_IDLE, TXK_TRAIN, TXK_DONE, TXK_DATA, TXK_LINK} slct_kind_t;

	// Training sequencer states.
	typedef enum logic [2:0] {ST_IDLE, ST_RCD, ST_TRAIN, ST_DONE, ST_LINK, ST_FAIL} slct_state_t;

	// Six supported-setting flags, in transmitted order.
	typedef struct packed {
		logic gen1_plain_ok;
		logic gen1_spread_ok;
		logic gen2_plain_ok;
		logic gen2_spread_ok;
		logic gen3_plain_ok;
		logic gen3_spread_ok;
	} slct_caps_t;

	// Outcome of the rate and multiplexing decision.
	typedef struct packed {
		logic       mux_en;
		slct_rate_t req_rate;
		slct_rate_t log_rate;
	} slct_neg_t;

endpackage

// ==== logic/slct_train.sv ====
// Capability word builder and checker with the training window sequencer.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Zero code: logical rate equals physical rate.
// - Both nonzero: take the lower rate.
// - Multiplex only in three rate cases.
// - Managed phy sends control-function rate code.
// - Slow window support forces gen1 plain.
// - Mid window support forces gen2 plain.
// - Six flags advertise rate and spreading.
// - Priority gen3 spread down to gen1 plain.
// - Parity makes total ones even.
// - Bad received parity flags reset problem.
// - Pattern is sequence plus 58 zeros.
// - Scrambler seeded once at delay end.
// - Train patterns start at delay end.
// - One train, four done patterns minimum.
// - Lock in limit: finish, then done.
// - No lock: train patterns until end.
// - Received data dwords are never compared.
// - Done seen: one more, then link valid.
// - No done before limit: window invalid.
// - Word layout, byte 0 first, MSB first.
// - Max train time 29,998,080 intervals.
// - Lock limit 28,497,920 intervals.
// - Rate change delay 750,000 intervals idle.
module slct_train
	import slct_pkg::*;
#(
	parameter int unsigned RCD_CYC_P = RCD_CYC,
	parameter int unsigned TLT_CYC_P = TLT_CYC,
	parameter int unsigned MTT_CYC_P = MTT_CYC
) (
	// Clock, reset and enable.
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	input  wire logic        ce_i,
	// Register port.
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	// Capability exchange.
	input  wire logic [31:0] rx_cap_i,
	input  wire logic        rx_cap_valid_i,
	input  wire slct_rate_t  phys_rate_i,
	output logic      [31:0] tx_cap_o,
	// Training link side.
	input  wire logic        dword_lock_i,
	input  wire logic        rx_train_done_i,
	output slct_kind_t       tx_kind_o,
	output logic      [31:0] tx_dword_o,
	// Outcome.
	output slct_neg_t        neg_o,
	output slct_caps_t       setting_o,
	output logic             train_valid_o,
	output logic             train_invalid_o,
	output logic             reset_problem_o
);

	// Map a nonzero rate code onto a line rate.
	function automatic slct_rate_t code_rate(input logic [3:0] code);
		if (code == RC_G1) begin
			return RATE_G1;
		end else if (code == RC_G2) begin
			return RATE_G2;
		end
		return RATE_G3;
	endfunction

	// Step the link-layer scrambler through one dword; output in the top bits.
	function automatic logic [47:0] scr_word(input logic [15:0] seed);
		logic [15:0] s;
		logic [31:0] o;
		logic        fb;
		s = seed;
		o = 32'h0000_0000;
		for (int i = 31; i >= 0; i--) begin
			o[i] = s[15];
			fb = s[15] ^ s[14] ^ s[12] ^ s[3];
			s = {s[14:0], fb};
		end
		return {o, s};
	endfunction

	// Configuration, last received word and sticky result flags.
	logic [31:0] cfg_reg;
	logic [31:0] rx_cap_reg;
	logic        rx_seen_reg;
	logic        exch_bad_reg;
	logic        parity_bad_reg;
	logic        no_common_reg;

	// Command strobes decoded from register writes.
	logic        start_cmd;
	logic        abort_cmd;
	assign start_cmd = wr_i && (addr_i == REG_CMD) && wdata_i[CMD_START_BIT];
	assign abort_cmd = wr_i && (addr_i == REG_CMD) && wdata_i[CMD_ABORT_BIT];

	// Transmitted and received capability fields, their common settings and the decision.
	logic [3:0]  tx_code;
	slct_caps_t  tx_caps;
	logic [31:0] tx_word;
	slct_caps_t  rx_caps;
	slct_caps_t  common;
	slct_caps_t  best;
	logic [3:0]  rx_code;
	slct_neg_t   neg;

	// Rate code source selection.
	always_comb begin
		tx_code = cfg_reg[CFG_MGMT_BIT] ? cfg_reg[CFG_PCTL_LSB +: 4] : cfg_reg[CFG_RATE_LSB +: 4];
	end

	// Setting flags as transmitted.
	always_comb begin
		tx_caps = slct_caps_t'(cfg_reg[CFG_SET_LSB +: 6]);
		if (cfg_reg[CFG_SLOW_BIT]) begin
			tx_caps.gen1_plain_ok = 1'b1;
		end
		if (cfg_reg[CFG_MID_BIT]) begin
			tx_caps.gen2_plain_ok = 1'b1;
		end
	end

	// Assemble the outgoing word; reserved bits stay zero.
	always_comb begin
		tx_word = 32'h0000_0000;
		tx_word[CAP_START_BIT] = 1'b1;
		tx_word[CAP_SHAPE_BIT] = cfg_reg[CFG_SHAPE_BIT];
		tx_word[CAP_RATE_LSB +: 4] = tx_code;
		tx_word[CAP_SET_LSB +: 6] = tx_caps;
		tx_word[CAP_PAR_BIT] = ^tx_word;
	end

	// Received fields with reserved positions discarded.
	always_comb begin
		rx_code = rx_cap_reg[CAP_RATE_LSB +: 4];
		rx_caps = slct_caps_t'(rx_cap_reg[CAP_SET_LSB +: 6]);
		common = tx_caps & rx_caps;
	end

	// Highest common setting as a one-hot value.
	always_comb begin
		best = '0;
		if (common.gen3_spread_ok) begin
			best.gen3_spread_ok = 1'b1;
		end else if (common.gen3_plain_ok) begin
			best.gen3_plain_ok = 1'b1;
		end else if (common.gen2_spread_ok) begin
			best.gen2_spread_ok = 1'b1;
		end else if (common.gen2_plain_ok) begin
			best.gen2_plain_ok = 1'b1;
		end else if (common.gen1_spread_ok) begin
			best.gen1_spread_ok = 1'b1;
		end else begin
			best.gen1_plain_ok = common.gen1_plain_ok;
		end
	end

	// Requested rate and multiplexing decision.
	always_comb begin
		neg.mux_en = 1'b0;
		neg.req_rate = phys_rate_i;
		if (tx_code == RC_NONE || rx_code == RC_NONE) begin
			neg.req_rate = phys_rate_i;
		end else begin
			neg.req_rate = code_rate((tx_code < rx_code) ? tx_code : rx_code);
		end
		neg.log_rate = phys_rate_i;
		if (tx_code != RC_NONE && rx_code != RC_NONE) begin
			if (neg.req_rate == RATE_G1 && phys_rate_i == RATE_G2) begin
				neg.mux_en = 1'b1;
				neg.log_rate = RATE_G1;
			end else if (neg.req_rate != RATE_G3 && phys_rate_i == RATE_G3) begin
				neg.mux_en = 1'b1;
				neg.log_rate = RATE_G2;
			end
		end
	end

	// Configuration register.
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_reg <= CFG_RST;
		end else if (ce_i && wr_i && addr_i == REG_CFG) begin
			cfg_reg <= wdata_i;
		end
	end

	// Registered copies of the words and decision.
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_cap_o  <= 32'h0000_0000;
			neg_o     <= '0;
			setting_o <= '0;
		end else if (ce_i) begin
			tx_cap_o  <= tx_word;
			neg_o     <= neg;
			setting_o <= best;
		end
	end

	// Capture the received word and check it; a new word wins over a clear.
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_cap_reg     <= 32'h0000_0000;
			rx_seen_reg    <= 1'b0;
			exch_bad_reg   <= 1'b0;
			parity_bad_reg <= 1'b0;
		end else if (ce_i) begin
			if (start_cmd) begin
				exch_bad_reg   <= 1'b0;
				parity_bad_reg <= 1'b0;
			end
			if (rx_cap_valid_i) begin
				rx_cap_reg  <= rx_cap_i & CAP_USED_MASK;
				rx_seen_reg <= 1'b1;
				if (rx_cap_i == 32'h0000_0000) begin
					exch_bad_reg <= 1'b1;
				// parity check over used bits only
				end else if (^(rx_cap_i & CAP_USED_MASK)) begin
					parity_bad_reg <= 1'b1;
				end
			end
		end
	end

	// Training sequencer state.
	slct_state_t state_reg;
	logic [31:0] win_cnt_reg;
	logic [5:0]  dw_idx_reg;
	logic [2:0]  done_cnt_reg;
	logic        lock_hit_reg;
	logic        rx_done_hit_reg;
	logic        finish_reg;
	logic [15:0] scr_reg;
	logic [47:0] scr_nxt;
	logic        pat_end;
	logic        mtt_end;
	logic        done_ok;

	assign scr_nxt = scr_word(scr_reg);
	assign pat_end = (dw_idx_reg == 6'(PATTERN_DW - 1));
	assign mtt_end = (win_cnt_reg >= 32'(MTT_CYC_P - 1));
	assign done_ok = (done_cnt_reg >= MIN_DONE) && (rx_done_hit_reg || rx_train_done_i);

	// Window timer and pattern position.
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			win_cnt_reg <= 32'h0000_0000;
			dw_idx_reg  <= 6'h00;
		end else if (ce_i) begin
			if (state_reg == ST_RCD && win_cnt_reg == 32'(RCD_CYC_P - 1)) begin
				win_cnt_reg <= 32'h0000_0000;
				dw_idx_reg  <= 6'h00;
			end else if (state_reg == ST_RCD) begin
				win_cnt_reg <= win_cnt_reg + 32'h1;
			end else if (state_reg == ST_TRAIN || state_reg == ST_DONE) begin
				if (!mtt_end) begin
					win_cnt_reg <= win_cnt_reg + 32'h1;
				end
				dw_idx_reg <= pat_end ? 6'h00 : dw_idx_reg + 6'h01;
			end else begin
				win_cnt_reg <= 32'h0000_0000;
				dw_idx_reg  <= 6'h00;
			end
		end
	end

	// Lock and received done-sequence memory within the window.
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lock_hit_reg    <= 1'b0;
			rx_done_hit_reg <= 1'b0;
		end else if (ce_i) begin
			if (state_reg == ST_TRAIN || state_reg == ST_DONE) begin
				if (dword_lock_i && win_cnt_reg < 32'(TLT_CYC_P)) begin
					lock_hit_reg <= 1'b1;
				end
				if (rx_train_done_i && !mtt_end) begin
					rx_done_hit_reg <= 1'b1;
				end
			end else begin
				lock_hit_reg    <= 1'b0;
				rx_done_hit_reg <= 1'b0;
			end
		end
	end

	// Scrambler runs over every training dword.
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scr_reg <= SCR_SEED;
		end else if (ce_i) begin
			if (state_reg == ST_RCD) begin
				scr_reg <= SCR_SEED;
			end else if (state_reg == ST_TRAIN || state_reg == ST_DONE) begin
				scr_reg <= scr_nxt[15:0];
			end
		end
	end

	// Main sequencer.
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg       <= ST_IDLE;
			done_cnt_reg    <= 3'h0;
			finish_reg      <= 1'b0;
			train_valid_o   <= 1'b0;
			train_invalid_o <= 1'b0;
			no_common_reg   <= 1'b0;
		end else if (ce_i) begin
			case (state_reg)
				ST_IDLE, ST_LINK, ST_FAIL: begin
					if (start_cmd) begin
						train_valid_o   <= 1'b0;
						train_invalid_o <= 1'b0;
						done_cnt_reg    <= 3'h0;
						finish_reg      <= 1'b0;
						no_common_reg   <= (best == '0);
						state_reg       <= (best == '0) ? ST_FAIL : ST_RCD;
					end
				end
				ST_RCD: begin
					if (win_cnt_reg == 32'(RCD_CYC_P - 1)) begin
						state_reg <= ST_TRAIN;
					end
				end
				ST_TRAIN: begin
					if (mtt_end) begin
						train_invalid_o <= 1'b1;
						state_reg       <= ST_FAIL;
					end else if (pat_end && lock_hit_reg) begin
						state_reg <= ST_DONE;
					end
				end
				ST_DONE: begin
					if (mtt_end && !finish_reg && !done_ok) begin
						train_invalid_o <= 1'b1;
						state_reg       <= ST_FAIL;
					end else if (pat_end) begin
						if (done_cnt_reg < MIN_DONE) begin
							done_cnt_reg <= done_cnt_reg + 3'h1;
						end
						if (finish_reg) begin
							train_valid_o <= 1'b1;
							state_reg     <= ST_LINK;
						end else if (done_cnt_reg + 3'h1 >= MIN_DONE &&
								(rx_done_hit_reg || rx_train_done_i)) begin
							finish_reg <= 1'b1;
						end
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
			if (abort_cmd) begin
				state_reg <= ST_IDLE;
			end
		end
	end

	// Transmit dword selection, registered.
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_kind_o  <= TXK_IDLE;
			tx_dword_o <= 32'h0000_0000;
		end else if (ce_i) begin
			tx_dword_o <= 32'h0000_0000;
			case (state_reg)
				ST_TRAIN, ST_DONE: begin
					if (dw_idx_reg < 6'(PSEQ_DW)) begin
						tx_kind_o <= (state_reg == ST_TRAIN) ? TXK_TRAIN : TXK_DONE;
					end else begin
						tx_kind_o  <= TXK_DATA;
						tx_dword_o <= scr_nxt[47:16];
					end
				end
				ST_LINK: tx_kind_o <= TXK_LINK;
				default: tx_kind_o <= TXK_IDLE;
			endcase
		end
	end

	// Reset problem is any failed check of the exchange or training.
	// incoming data dwords are not examined
	assign reset_problem_o = parity_bad_reg || exch_bad_reg || no_common_reg || train_invalid_o;

	// Register read, data one cycle after the strobe; unmapped reads zero.
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (ce_i) begin
			rdata_o <= 32'h0000_0000;
			if (rd_i) begin
				case (addr_i)
					REG_CFG:   rdata_o <= cfg_reg;
					REG_TXCAP: rdata_o <= tx_cap_o;
					REG_RXCAP: rdata_o <= rx_cap_reg;
					REG_STAT: begin
						rdata_o <= {12'h000, state_reg, setting_o, neg_o,
							no_common_reg, train_invalid_o, train_valid_o,
							parity_bad_reg, exch_bad_reg, rx_seen_reg};
					end
					default:   rdata_o <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule

`default_nettype wire

// ==== test/slct_train_asserts.sv ====
// Port-level property checker for the capability and training block.
`timescale 1ns/100ps
`default_nettype none
module slct_train_asserts
	import slct_pkg::*;
(
	// Clock, reset and enable.
	input wire logic        mclk_i,
	input wire logic        rst_n_i,
	input wire logic        ce_i,
	// Register port.
	input wire logic [7:0]  addr_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	// Capability exchange.
	input wire logic [31:0] rx_cap_i,
	input wire logic        rx_cap_valid_i,
	input wire logic [31:0] tx_cap_o,
	// Training and outcome.
	input wire slct_kind_t  tx_kind_o,
	input wire slct_neg_t   neg_o,
	input wire slct_caps_t  setting_o,
	input wire logic        train_valid_o,
	input wire logic        train_invalid_o,
	input wire logic        reset_problem_o
);
	// Every check runs on the one clock and is quiet during reset.
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	cap_frame_a: assert property (tx_cap_o != 32'h0 |-> tx_cap_o[CAP_START_BIT] && !(^tx_cap_o)
		&& ((tx_cap_o & ~CAP_USED_MASK) == 32'h0)) else $error("bad transmitted word");
	mux_case_a: assert property (neg_o.mux_en |-> neg_o.req_rate != RATE_G3
		&& neg_o.log_rate != RATE_G3) else $error("mux at wrong rate");
	one_setting_a: assert property ($onehot0(setting_o)) else $error("setting not one-hot");
	seq_len_a: assert property (tx_kind_o inside {TXK_TRAIN, TXK_DONE} && !$stable(tx_kind_o)
		|-> ##1 ($stable(tx_kind_o) || train_invalid_o)[*5] ##1 (tx_kind_o == TXK_DATA
		|| train_invalid_o)) else $error("sequence length wrong");
	data_len_a: assert property (tx_kind_o == TXK_DATA && $past(tx_kind_o) != TXK_DATA
		|-> ##57 (tx_kind_o == TXK_DATA || train_invalid_o) ##1 tx_kind_o != TXK_DATA)
		else $error("data run wrong");
	par_bad_a: assert property (ce_i && rx_cap_valid_i && (rx_cap_i & CAP_USED_MASK) != 0
		&& ^(rx_cap_i & CAP_USED_MASK) |=> reset_problem_o) else $error("parity not flagged");
	zero_word_a: assert property (ce_i && rx_cap_valid_i && rx_cap_i == 32'h0
		|=> reset_problem_o) else $error("zero word not flagged");
	excl_out_a: assert property (train_valid_o |-> !train_invalid_o) else $error("both outcomes");
	inv_prob_a: assert property ($rose(train_invalid_o) |-> reset_problem_o)
		else $error("invalid without problem");
	valid_link_a: assert property ($rose(train_valid_o) |-> ##[0:2] tx_kind_o == TXK_LINK)
		else $error("no link dwords");
	txcap_read_a: assert property (ce_i && rd_i && addr_i == REG_TXCAP
		|=> rdata_o == $past(tx_cap_o)) else $error("read of word wrong");

	// Main scenarios reached.
	cover property ($rose(train_valid_o));
	cover property ($rose(train_invalid_o));
	cover property (neg_o.mux_en);
endmodule
bind slct_train slct_train_asserts chk_u (.mclk_i, .rst_n_i, .ce_i, .addr_i, .rd_i, .rdata_o,
	.rx_cap_i, .rx_cap_valid_i, .tx_cap_o, .tx_kind_o, .neg_o, .setting_o, .train_valid_o,
	.train_invalid_o, .reset_problem_o);
`default_nettype wire

// ==== test/slct_peer.sv ====
// Behavioural model of the attached peer phy.
`timescale 1ns/100ps
`default_nettype none
module slct_peer
	import slct_pkg::*;
(
	// Clock and reset.
	input wire logic        mclk_i,
	input wire logic        rst_n_i,
	// Controls from the bench.
	input wire logic [31:0] cap_i,
	input wire logic        send_i,
	input wire logic [31:0] lock_dly_i,
	input wire logic        done_en_i,
	input wire slct_kind_t  dut_kind_i,
	// Lines into the block.
	output logic      [31:0] rx_cap_o,
	output logic             rx_cap_valid_o,
	output logic             dword_lock_o,
	output logic             rx_train_done_o
);
	int cnt; // Cycles since the block began sending patterns.

	// The word is shown with its pulse; between words the line flips every cycle.
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_cap_o       <= 32'h0;
			rx_cap_valid_o <= 1'b0;
		end else begin
			rx_cap_valid_o <= send_i;
			rx_cap_o       <= send_i ? cap_i : ~rx_cap_o;
		end
	end

	// Lock follows a set delay; done sequences come once a pattern after lock.
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt             <= 0;
			dword_lock_o    <= 1'b0;
			rx_train_done_o <= 1'b0;
		end else begin
			cnt             <= (dut_kind_i == TXK_IDLE) ? 0 : cnt + 1;
			dword_lock_o    <= (dut_kind_i != TXK_IDLE) && (cnt >= int'(lock_dly_i));
			rx_train_done_o <= done_en_i && dword_lock_o && (cnt[5:0] == 6'h0);
		end
	end
endmodule
`default_nettype wire

// ==== test/serial_link_capability_and_training_bench.sv ====
// Self-checking bench for the capability and training block.
`timescale 1ns/100ps
`default_nettype none
module serial_link_capability_and_training_bench;
	import slct_pkg::*;
	localparam int unsigned RCD_P = 8;
	localparam int unsigned TLT_P = 600;
	localparam int unsigned MTT_P = 1024;
	logic        mclk_i, rst_n_i, ce_i, wr_i, rd_i, rx_cap_valid_i, dword_lock_i;
	logic        rx_train_done_i, train_valid_o, train_invalid_o, reset_problem_o;
	logic        send, done_en, rd_seen;
	logic [7:0]  addr_i;
	logic [31:0] wdata_i, rdata_o, rx_cap_i, tx_cap_o, tx_dword_o, cap_w, cfg, rw, txe, msk, f0;
	logic [31:0] fd [2];
	logic [63:0] note;
	logic [63:0] exp_q [$];
	logic [5:0]  cmn;
	logic [3:0]  codes [5] = '{4'h0, 4'h8, 4'h9, 4'ha, 4'hb};
	slct_rate_t  phys_rate_i;
	slct_kind_t  tx_kind_o, pk;
	slct_neg_t   neg_o;
	slct_caps_t  setting_o;
	int          errors, checks, n_tr, n_dn, k, lock_dly;

	slct_train #(.RCD_CYC_P(RCD_P), .TLT_CYC_P(TLT_P), .MTT_CYC_P(MTT_P)) dut_u (.mclk_i, .rst_n_i,
		.ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .rx_cap_i, .rx_cap_valid_i, .phys_rate_i,
		.tx_cap_o, .dword_lock_i, .rx_train_done_i, .tx_kind_o, .tx_dword_o, .neg_o, .setting_o,
		.train_valid_o, .train_invalid_o, .reset_problem_o);
	slct_peer peer_u (.mclk_i, .rst_n_i, .cap_i(cap_w), .send_i(send), .lock_dly_i(lock_dly),
		.done_en_i(done_en), .dut_kind_i(tx_kind_o), .rx_cap_o(rx_cap_i),
		.rx_cap_valid_o(rx_cap_valid_i), .dword_lock_o(dword_lock_i),
		.rx_train_done_o(rx_train_done_i));

	// Free-running 40 MHz clock.
	initial begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end

	// Compares one value and reports a mismatch.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic summarize();
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// One-cycle register write.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask

	// One-cycle register read; the expected value and mask go onto the queue.
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		exp_q.push_back({m, e & m});
		@(posedge mclk_i);
		rd_i <= 1'b0;
	endtask

	// Has the peer deliver one capability word and lets the outputs settle.
	task automatic cap(input logic [31:0] w);
		@(posedge mclk_i);
		cap_w <= w;
		send  <= 1'b1;
		@(posedge mclk_i);
		send <= 1'b0;
		repeat (3) @(posedge mclk_i);
	endtask

	// Expected transmitted word for a configuration value.
	function automatic logic [31:0] txw(input logic [31:0] c);
		logic [5:0]  f;
		logic [31:0] w;
		f    = c[5:0] | {c[17], 1'b0, c[18], 3'h0};
		w    = {1'b1, c[8], 2'h0, c[16] ? c[23:20] : c[15:12], f, 18'h0};
		w[0] = ^w;
		return w;
	endfunction

	// Rate index of a nonzero requested code.
	function automatic logic [1:0] rmap(input logic [3:0] c);
		return (c == 4'h8) ? 2'h0 : ((c == 4'h9) ? 2'h1 : 2'h2);
	endfunction

	// Expected {mux, requested, logical} for two codes and a physical rate.
	function automatic logic [4:0] negx(input logic [3:0] t, input logic [3:0] r,
		input logic [1:0] p);
		logic [1:0] q;
		logic       m;
		q = (t == 4'h0 || r == 4'h0) ? p : ((rmap(t) < rmap(r)) ? rmap(t) : rmap(r));
		m = q < p;
		return {m, q, m ? ((q == 2'h0 && p == 2'h2) ? 2'h1 : q) : p};
	endfunction

	// Notes which reads were taken so their answers can be checked.
	always @(posedge mclk_i) rd_seen <= rd_i;

	// Takes the oldest note whenever read data stand.
	always @(negedge mclk_i) begin
		if (rd_seen) begin
			note = exp_q.pop_front();
			chk(rdata_o & note[63:32], note[31:0]);
		end
	end

	// Counts patterns and keeps the first data dword of the first two.
	always @(negedge mclk_i) begin
		if (tx_kind_o != pk) begin
			if (tx_kind_o == TXK_TRAIN) n_tr++;
			if (tx_kind_o == TXK_DONE) n_dn++;
			if (tx_kind_o == TXK_DATA && n_tr + n_dn <= 2) fd[n_tr + n_dn - 1] = tx_dword_o;
		end
		pk = tx_kind_o;
	end

	// Starts a training window and waits for its outcome.
	task automatic train(input int l, input logic d, input logic v);
		lock_dly <= l;
		done_en  <= d;
		n_tr = 0;
		n_dn = 0;
		wr(REG_CMD, 32'h1);
		k = 1;
		@(negedge mclk_i);
		while (tx_kind_o !== TXK_TRAIN && k < 100) begin
			@(negedge mclk_i);
			k++;
		end
		chk(k, RCD_P + 2);
		k = 0;
		while (train_valid_o !== 1'b1 && train_invalid_o !== 1'b1 && k < 2000) begin
			@(negedge mclk_i);
			k++;
		end
		repeat (3) @(negedge mclk_i);
		chk(train_valid_o, v);
		chk(train_invalid_o, !v);
	endtask

	// Gives up on a hung run.
	initial begin
		#400us;
		errors++;
		summarize();
	end

	// Main sequence.
	initial begin
		{rst_n_i, wr_i, rd_i, send, done_en, rd_seen} = '0;
		ce_i        = 1'b1;
		addr_i      = 8'h0;
		wdata_i     = 32'h0;
		cap_w       = 32'h0;
		lock_dly    = 0;
		phys_rate_i = RATE_G1;
		k           = $urandom(32'h772320a6);
		repeat (4) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		rd(REG_CFG, '1, CFG_RST);
		rd(REG_STAT, '1, 32'h0);
		rd(8'h14, '1, 32'h0);
		$display("reset values done");
		for (int i = 0; i < 60; i++) begin
			cfg            = $urandom & 32'h00f7_f13f;
			cfg[15:12]     = codes[i % 4];
			cfg[23:20]     = codes[(i + 1) % 4];
			phys_rate_i   <= slct_rate_t'(i / 20);
			rw             = $urandom;
			rw[31]         = 1'b1;
			rw[27:24]      = codes[(i / 4) % 5];
			rw[0]          = 1'b0;
			rw[0]          = ^(rw & CAP_USED_MASK);
			wr(REG_CFG, cfg);
			cap(rw);
			txe = txw(cfg);
			cmn = txe[23:18] & rw[23:18];
			msk = 32'h000f_ffff;
			rd(REG_TXCAP, '1, txe);
			rd(REG_RXCAP, '1, rw & CAP_USED_MASK);
			// The no-common flag only moves on a start command, so it stays clear here.
			rd(REG_STAT, msk, {15'h0, cmn & (~cmn + 6'h1), negx(txe[27:24], rw[27:24],
				2'(i / 20)), 1'b0, 5'h01});
		end
		$display("negotiation done");
		cap(rw ^ 32'h1);
		rd(REG_STAT, 32'h4, 32'h4);
		chk(reset_problem_o, 1'b1);
		wr(REG_CFG, 32'h0);
		wr(REG_CMD, 32'h1);
		rd(REG_STAT, 32'h000e_0024, 32'h000a_0020);
		chk(reset_problem_o, 1'b1);
		wr(REG_CMD, 32'h2);
		cap(32'h0);
		rd(REG_STAT, 32'h6, 32'h2);
		chk(reset_problem_o, 1'b1);
		$display("faulty words done");
		wr(REG_CFG, 32'h0006_0008);
		// A write while the enable is low must leave the configuration alone.
		ce_i <= 1'b0;
		wr(REG_CFG, 32'h0);
		ce_i <= 1'b1;
		phys_rate_i <= RATE_G2;
		cap(32'h8020_0000);
		rd(REG_CFG, '1, 32'h0006_0008);
		train(100, 1'b1, 1'b1);
		chk(n_tr, 32'h2);
		chk(n_dn, 32'h5);
		chk(tx_kind_o, TXK_LINK);
		chk(fd[0] != fd[1], 1'b1);
		f0 = fd[0];
		rd(REG_STAT, 32'h000e_0018, 32'h0008_0008);
		train(100, 1'b0, 1'b0);
		chk(n_tr, 32'h2);
		chk(n_dn > 3, 1'b1);
		chk(reset_problem_o, 1'b1);
		train(100000, 1'b1, 1'b0);
		chk(n_dn, 32'h0);
		chk(fd[0], f0);
		$display("training done");
		repeat (3) @(posedge mclk_i);
		summarize();
	end
endmodule
`default_nettype wire
